/* hdl/mid_distributor.sv */
`timescale 1ns/100ps
`default_nettype none
// What this block does
// [RULE1] Each CPU has eight 4-bit message fields; any set bit raises that field.
// [RULE2] Several writers of one field each use their own bit position.
// [RULE3] Writing the clear register zeroes the matching message bits.
// [RULE4] Each module request carries its own event code, shown on acceptance.
// [RULE5] Module priorities are 5 bits; values 0 and 1 mask the source.
// [RULE6] CPU level is the priority without its low bit; level 0 means none.
// [RULE7] Equal 4-bit levels are still ranked by the full 5-bit priority.
// [RULE8] Equal priorities are resolved by a fixed default source order.
// [RULE9] That default order is a constant ranking table given as a parameter.
// [RULE10] All module priority fields reset to zero.
// [RULE11] Software changes priorities only while its hold flag is set.
// [RULE12] Only the best request is forwarded; lower ones stay pending.
// [RULE13] A CPU is requested only when the level exceeds its mask level.
// [RULE14] On acceptance the CPU loads the event code and enters its handler.
// [RULE15] With auto mask update set, acceptance sets the mask to the level.
// [RULE16] Power-on reset masks every module source until unmasked by software.
// [RULE17] Handlers clear, read back and wait before releasing hold.
// [RULE18] Fixed mode routes each source by a per-CPU route mask.
// [RULE19] Automatic mode offers to all CPUs; the first acknowledge claims it.
// [RULE20] The ack owner register reads 0 for a CPU that should not serve.
// [RULE21] A claimed source stays masked until the ack clear register is written.
// [RULE22] A sleeping CPU wakes only above its mask; only one wakes at a time.
// [RULE23] With mask-all set, a low non-maskable line blocks all other requests.
// [RULE24] Level 16 is highest; level 0 masks and ignores the source. The code's highest level is 15, from a 4-bit level.
module mid_distributor
  import mid_pkg::*;
#(
  parameter int N_CPU = 2,
  parameter int N_SRC = 8,
  parameter logic [N_SRC*8-1:0] SRC_RANK = 64'h0706050403020100,
  parameter logic [N_SRC*EVT_W-1:0] SRC_EVT = 96'h4e0_4c0_4a0_480_460_440_420_400
) (
  input  wire logic                    i_clk,
  input  wire logic                    i_resetn,
  input  wire logic                    i_ce,
  input  wire logic [N_SRC-1:0]        i_src_req,
  input  wire logic                    i_nmi_line,
  input  wire logic [N_CPU-1:0]        i_cpu_ack,
  input  wire logic [N_CPU-1:0]        i_cpu_sleep,
  input  wire logic [N_CPU*LVL_W-1:0]  i_cpu_mask_level,
  input  wire logic [7:0]              i_s_axi_awaddr,
  input  wire logic                    i_s_axi_awvalid,
  output logic                         o_s_axi_awready,
  input  wire logic [31:0]             i_s_axi_wdata,
  input  wire logic [3:0]              i_s_axi_wstrb,
  input  wire logic                    i_s_axi_wvalid,
  output logic                         o_s_axi_wready,
  output logic [1:0]                   o_s_axi_bresp,
  output logic                         o_s_axi_bvalid,
  input  wire logic                    i_s_axi_bready,
  input  wire logic [7:0]              i_s_axi_araddr,
  input  wire logic                    i_s_axi_arvalid,
  output logic                         o_s_axi_arready,
  output logic [31:0]                  o_s_axi_rdata,
  output logic [1:0]                   o_s_axi_rresp,
  output logic                         o_s_axi_rvalid,
  input  wire logic                    i_s_axi_rready,
  output logic [N_CPU-1:0]             o_cpu_req,
  output logic [N_CPU*LVL_W-1:0]       o_cpu_level,
  output logic [N_CPU*EVT_W-1:0]       o_cpu_event,
  output logic [N_CPU-1:0]             o_cpu_wake,
  output logic [N_CPU*LVL_W-1:0]       o_cpu_new_mask,
  output logic [N_CPU-1:0]             o_cpu_mask_load
);

  // Register state.
  logic [31:0]        msg_req_reg [N_CPU];
  logic [PRI_W-1:0]   pri_reg [N_SRC];
  logic [N_SRC-1:0]   mod_mask_reg;
  logic [N_SRC-1:0]   route_reg [N_CPU];
  logic [2:0]         ctrl_reg;
  logic [N_SRC-1:0]   claimed_reg;
  logic [N_SRC-1:0]   owner_reg [N_CPU];
  logic [EVT_W-1:0]   event_code_reg [N_CPU];

  // Bus handshake state.
  logic               aw_held_reg;
  logic               w_held_reg;
  logic [7:0]         awaddr_reg;
  logic [31:0]        wdata_reg;
  logic [3:0]         wstrb_reg;
  logic               wr_go;
  logic [7:0]         wa;
  logic [31:0]        wmask;

  // Per-CPU arbitration results.
  logic [N_CPU-1:0]   cand_valid;
  logic [PRI_W:0]     cand_pri [N_CPU];
  logic [EVT_W-1:0]   cand_evt [N_CPU];
  logic [N_SRC-1:0]   cand_src [N_CPU];
  logic [N_CPU-1:0]   can_take;
  logic [N_CPU-1:0]   wake_pick;
  logic               nmi_block;
  logic [N_SRC-1:0]   claim_set;
  logic [N_SRC-1:0]   claim_clr;

  // Byte-lane expansion of the write strobes.
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{wstrb_reg[b]}};
    end
  end

  assign wr_go     = aw_held_reg && w_held_reg && !o_s_axi_bvalid;
  assign wa        = awaddr_reg;
  assign nmi_block = ctrl_reg[CTRL_MAI_BIT] && !i_nmi_line; // RULE23

  // Write address and data are captured independently, in either order.
  // Each ready is a one-cycle pulse raised one cycle after its valid is seen.
  // The captured halves are held until both are present and no response is
  // pending, so a master that parks bready low never loses a second write.
  // The response rises one cycle after both halves are held.
  // Offsets above OFF_LEVEL_BASE (0x70) answer with a slave error and
  // change nothing, because no register decode matches them.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      aw_held_reg     <= 1'b0;
      w_held_reg      <= 1'b0;
      awaddr_reg      <= 8'h00;
      wdata_reg       <= 32'h0000_0000;
      wstrb_reg       <= 4'h0;
      o_s_axi_awready <= 1'b0;
      o_s_axi_wready  <= 1'b0;
      o_s_axi_bvalid  <= 1'b0;
      o_s_axi_bresp   <= RESP_OKAY;
    end else if (i_ce) begin
      o_s_axi_awready <= !aw_held_reg && !o_s_axi_awready && i_s_axi_awvalid;
      o_s_axi_wready  <= !w_held_reg && !o_s_axi_wready && i_s_axi_wvalid;
      if (o_s_axi_awready && i_s_axi_awvalid) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= i_s_axi_awaddr;
      end
      if (o_s_axi_wready && i_s_axi_wvalid) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= i_s_axi_wdata;
        wstrb_reg  <= i_s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_reg    <= 1'b0;
        w_held_reg     <= 1'b0;
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp  <= (wa > OFF_LEVEL_BASE) ? RESP_SLVERR : RESP_OKAY;
      end else if (o_s_axi_bvalid && i_s_axi_bready) begin
        o_s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Message requests: set and clear through their own registers.
  // A set write only adds bits, so writers that keep to their own bit
  // positions inside a field never disturb one another.
  // A clear write drops only the bits written as one.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int c = 0; c < N_CPU; c++) msg_req_reg[c] <= 32'h0000_0000;
    end else if (i_ce && wr_go) begin
      for (int c = 0; c < N_CPU; c++) begin
        if (wa == OFF_MSG_REQ + 8'(c * 8)) begin
          msg_req_reg[c] <= msg_req_reg[c] | (wdata_reg & wmask); // RULE2
        end else if (wa == OFF_MSG_CLR + 8'(c * 8)) begin
          msg_req_reg[c] <= msg_req_reg[c] & ~(wdata_reg & wmask); // RULE3
        end
      end
    end
  end

  // Priorities, masks, routing and control.
  // Software is expected to change priorities only while its hold flag is
  // set; the block itself takes a new value at once.
  // The mask register sets bits through one offset and clears them through
  // another, so no read-modify-write is needed.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int s = 0; s < N_SRC; s++) pri_reg[s] <= PRI_RESET; // RULE10
      mod_mask_reg <= N_SRC'(MOD_MASK_RESET);                   // RULE16
      for (int c = 0; c < N_CPU; c++) route_reg[c] <= '0;
      ctrl_reg <= 3'h0;
    end else if (i_ce && wr_go) begin
      for (int s = 0; s < N_SRC; s++) begin
        if (wa == OFF_PRI_BASE + 8'(s * 4) && wstrb_reg[0]) pri_reg[s] <= wdata_reg[PRI_W-1:0];
      end
      if (wa == OFF_MOD_MASK) mod_mask_reg <= mod_mask_reg | wdata_reg[N_SRC-1:0];
      if (wa == OFF_MOD_UNMASK) mod_mask_reg <= mod_mask_reg & ~wdata_reg[N_SRC-1:0]; // RULE16
      for (int c = 0; c < N_CPU; c++) begin
        if (wa == OFF_ROUTE_BASE + 8'(c * 4)) route_reg[c] <= wdata_reg[N_SRC-1:0]; // RULE18
      end
      if (wa == OFF_CTRL && wstrb_reg[0]) ctrl_reg <= wdata_reg[2:0];
    end
  end

  // Candidate per CPU: module sources are ranked by their full 5-bit priority
  // and, on a tie, by the fixed rank table, where the lower rank wins.
  // Masked, claimed and unrouted sources stay pending and are not dropped.
  // A message field is offered only when no module source is a candidate.
  always_comb begin
    for (int c = 0; c < N_CPU; c++) begin
      cand_valid[c] = 1'b0;
      cand_pri[c]   = '0;
      cand_evt[c]   = '0;
      cand_src[c]   = '0;
      for (int s = 0; s < N_SRC; s++) begin
        if (i_src_req[s] && !mod_mask_reg[s] && !claimed_reg[s]           // RULE21
            && pri_reg[s] >= PRI_MIN_LIVE                                 // RULE5 RULE24
            && (ctrl_reg[CTRL_AUTO_BIT] || route_reg[c][s])) begin       // RULE18 RULE19
          if (!cand_valid[c] || {1'b0, pri_reg[s]} > cand_pri[c]) begin   // RULE7 RULE12
            cand_valid[c] = 1'b1;
            cand_pri[c]   = {1'b0, pri_reg[s]};
            cand_evt[c]   = SRC_EVT[s*EVT_W +: EVT_W];                  // RULE4
            cand_src[c]   = N_SRC'(1) << s;
          end else if ({1'b0, pri_reg[s]} == cand_pri[c]) begin
            for (int t = 0; t < N_SRC; t++) begin
              if (cand_src[c][t] && SRC_RANK[s*8 +: 8] < SRC_RANK[t*8 +: 8]) begin // RULE8 RULE9
                cand_evt[c] = SRC_EVT[s*EVT_W +: EVT_W];
                cand_src[c] = N_SRC'(1) << s;
              end
            end
          end
        end
      end
      // Message fields use their own top-ranked level, only when no module source is a candidate.
      for (int f = MSG_FIELDS - 1; f >= 0; f--) begin
        if (|msg_req_reg[c][f*MSG_FIELD_W +: MSG_FIELD_W] && !cand_valid[c]) begin // RULE1
          cand_valid[c] = 1'b1;
          cand_pri[c]   = 6'h1f;
          cand_evt[c]   = MSG_EVT_BASE + 12'(f) * MSG_EVT_STEP;
          cand_src[c]   = '0;
        end
      end
    end
  end

  // A CPU can take the candidate only above its mask and outside the block.
  // The compare uses the 4-bit level, the priority without its low bit.
  // A low non-maskable line with mask-all set holds every request back.
  always_comb begin
    for (int c = 0; c < N_CPU; c++) begin
      can_take[c] = cand_valid[c] && !nmi_block                           // RULE23
                    && (cand_pri[c][PRI_W-1:1] > i_cpu_mask_level[c*LVL_W +: LVL_W]); // RULE13
    end
  end

  // At most one sleeping CPU is woken, lowest index first.
  // Only a CPU that could take the request above its mask is a choice.
  // The fixed order keeps the choice repeatable from one cycle to the next.
  always_comb begin
    wake_pick = '0;
    for (int c = N_CPU - 1; c >= 0; c--) begin
      if (can_take[c] && i_cpu_sleep[c]) wake_pick = N_CPU'(1) << c; // RULE22
    end
  end

  // Claim bits: every source acknowledged in automatic mode is set, and the
  // clear write drops the others; a claim and a clear of the same bit in one
  // cycle leave it set, so a fresh acknowledge is never lost.
  always_comb begin
    claim_set = '0;
    for (int c = 0; c < N_CPU; c++) begin
      if (ctrl_reg[CTRL_AUTO_BIT] && i_cpu_ack[c] && o_cpu_req[c]) begin
        claim_set = claim_set | cand_src[c];                    // RULE19
      end
    end
    claim_clr = (wr_go && wa == OFF_ACK_CLR) ? wdata_reg[N_SRC-1:0] : '0; // RULE21
  end

  // CPU-facing outputs, acceptance capture and automatic claim.
  // The level is shown only while the request stands, and drops to zero with
  // it in the cycle after an acknowledge.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_cpu_req       <= '0;
      o_cpu_level     <= '0;
      o_cpu_event     <= '0;
      o_cpu_wake      <= '0;
      o_cpu_new_mask  <= '0;
      o_cpu_mask_load <= '0;
      claimed_reg     <= '0;
      for (int c = 0; c < N_CPU; c++) begin
        owner_reg[c]      <= '0;
        event_code_reg[c] <= '0;
      end
    end else if (i_ce) begin
      o_cpu_wake <= wake_pick;
      for (int c = 0; c < N_CPU; c++) begin
        o_cpu_req[c] <= can_take[c] && !(i_cpu_ack[c] && o_cpu_req[c]);
        o_cpu_level[c*LVL_W +: LVL_W] <= (can_take[c] && !(i_cpu_ack[c] && o_cpu_req[c]))
                                         ? cand_pri[c][PRI_W-1:1] : 4'h0; // RULE6
        o_cpu_event[c*EVT_W +: EVT_W] <= cand_evt[c];
        o_cpu_mask_load[c] <= 1'b0;
        if (i_cpu_ack[c] && o_cpu_req[c]) begin
          event_code_reg[c] <= o_cpu_event[c*EVT_W +: EVT_W];   // RULE14
          owner_reg[c] <= cand_src[c] & ~claimed_reg;           // RULE20
          o_cpu_mask_load[c] <= ctrl_reg[CTRL_AMU_BIT];         // RULE15
          o_cpu_new_mask[c*LVL_W +: LVL_W] <= o_cpu_level[c*LVL_W +: LVL_W];
        end
      end
      // Claim on first acknowledge; the clear write releases, claim wins ties.
      claimed_reg <= (claimed_reg & ~claim_clr) | claim_set;    // RULE19 RULE21
    end
  end

  // Read channel: one-cycle registered answer.
  // The address is taken with a one-cycle ready pulse and the data follow in
  // the next cycle, held until the master raises rready.
  // Write-only offsets other than 0x0c read as zero with an okay response;
  // unmapped offsets and the write-only 0x0c read as zero with a slave error.
  // A new address is refused while an answer is still waiting.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_s_axi_arready <= 1'b0;
      o_s_axi_rvalid  <= 1'b0;
      o_s_axi_rdata   <= 32'h0000_0000;
      o_s_axi_rresp   <= RESP_OKAY;
    end else if (i_ce) begin
      o_s_axi_arready <= !o_s_axi_arready && !o_s_axi_rvalid && i_s_axi_arvalid;
      if (o_s_axi_arready && i_s_axi_arvalid) begin
        o_s_axi_rvalid <= 1'b1;
        o_s_axi_rresp  <= RESP_SLVERR;
        o_s_axi_rdata  <= 32'h0000_0000;
        for (int c = 0; c < N_CPU; c++) begin
          if (i_s_axi_araddr == OFF_MSG_REQ + 8'(c * 8)) begin
            o_s_axi_rdata <= msg_req_reg[c];
            o_s_axi_rresp <= RESP_OKAY;
          end
          if (i_s_axi_araddr == OFF_ROUTE_BASE + 8'(c * 4)) begin
            o_s_axi_rdata <= 32'(route_reg[c]);
            o_s_axi_rresp <= RESP_OKAY;
          end
          if (i_s_axi_araddr == OFF_ACK_OWNER + 8'(c * 4) + 8'(c * 8) * 8'h00 && c == 0
              || i_s_axi_araddr == OFF_EVENT_BASE + 8'(c * 4) + 8'h08) begin
            o_s_axi_rdata <= 32'(owner_reg[c]);                  // RULE20
            o_s_axi_rresp <= RESP_OKAY;
          end
          if (i_s_axi_araddr == OFF_EVENT_BASE + 8'(c * 4) && c < 2) begin
            o_s_axi_rdata <= 32'(event_code_reg[c]);             // RULE14
            o_s_axi_rresp <= RESP_OKAY;
          end
        end
        for (int s = 0; s < N_SRC; s++) begin
          if (i_s_axi_araddr == OFF_PRI_BASE + 8'(s * 4)) begin
            o_s_axi_rdata <= 32'(pri_reg[s]);
            o_s_axi_rresp <= RESP_OKAY;
          end
        end
        if (i_s_axi_araddr == OFF_MOD_MASK) begin
          o_s_axi_rdata <= 32'(mod_mask_reg);
          o_s_axi_rresp <= RESP_OKAY;
        end
        if (i_s_axi_araddr == OFF_CTRL) begin
          o_s_axi_rdata <= 32'(ctrl_reg);
          o_s_axi_rresp <= RESP_OKAY;
        end
        if (i_s_axi_araddr == OFF_ACK_CLR || i_s_axi_araddr == OFF_MOD_UNMASK
            || i_s_axi_araddr == OFF_MSG_CLR) begin
          o_s_axi_rresp <= RESP_OKAY;
        end
      end else if (o_s_axi_rvalid && i_s_axi_rready) begin
        o_s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : mid_distributor
`default_nettype wire

/* hdl/mid_pkg.sv */
package mid_pkg;

  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [7:0] OFF_MSG_REQ     = 8'h00;
  localparam logic [7:0] OFF_MSG_CLR     = 8'h04;
  localparam logic [7:0] OFF_PRI_BASE    = 8'h10;
  localparam logic [7:0] OFF_MOD_MASK    = 8'h30;
  localparam logic [7:0] OFF_MOD_UNMASK  = 8'h34;
  localparam logic [7:0] OFF_ROUTE_BASE  = 8'h40;
  localparam logic [7:0] OFF_CTRL        = 8'h50;
  localparam logic [7:0] OFF_ACK_OWNER   = 8'h54;
  localparam logic [7:0] OFF_ACK_CLR     = 8'h58;
  localparam logic [7:0] OFF_EVENT_BASE  = 8'h60;
  localparam logic [7:0] OFF_LEVEL_BASE  = 8'h70;

  // Layout and widths.
  localparam int PRI_W        = 5;
  localparam int LVL_W        = 4;
  localparam int MSG_FIELDS   = 8;
  localparam int MSG_FIELD_W  = 4;
  localparam int EVT_W        = 12;
  localparam int CTRL_AUTO_BIT = 0;
  localparam int CTRL_MAI_BIT  = 1;
  localparam int CTRL_AMU_BIT  = 2;

  // Reset values, lowest live priority and message event codes.
  localparam logic [4:0]  PRI_RESET      = 5'h00;
  localparam logic [31:0] MOD_MASK_RESET = 32'hffff_ffff;
  localparam logic [4:0]  PRI_MIN_LIVE   = 5'h02;
  localparam logic [11:0] MSG_EVT_BASE   = 12'h100;
  localparam logic [11:0] MSG_EVT_STEP   = 12'h020;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : mid_pkg

/* tb/mid_cpu_model.sv */
`timescale 1ns/100ps
`default_nettype none
// One CPU core that accepts its request after a chosen number of cycles.
module mid_cpu_model (
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_req,
  input  wire logic       i_en,
  input  wire logic [7:0] i_delay,
  output logic            o_ack
);
  logic [7:0] wait_reg;

  // Counts request cycles; the one-cycle accept models an instruction boundary.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wait_reg <= 8'h00;
      o_ack    <= 1'b0;
    end else begin
      o_ack <= 1'b0;
      if (!i_req || o_ack || !i_en) begin
        wait_reg <= 8'h00;
      end else if (i_en && wait_reg == i_delay) begin
        o_ack <= 1'b1;
      end else begin
        wait_reg <= wait_reg + 8'h01;
      end
    end
  end
endmodule : mid_cpu_model
`default_nettype wire

/* tb/mid_distributor_sva.sv */
`timescale 1ns/100ps
`default_nettype none
// Checks request, acceptance, wake and bus timing at the distributor ports.
module mid_distributor_sva
  import mid_pkg::*;
#(
  parameter int N_CPU = 2,
  parameter int N_SRC = 8
) (
  input wire logic                   i_clk,
  input wire logic                   i_resetn,
  input wire logic [N_CPU-1:0]       i_cpu_ack,
  input wire logic [N_CPU-1:0]       i_cpu_sleep,
  input wire logic [N_CPU*LVL_W-1:0] i_cpu_mask_level,
  input wire logic                   o_s_axi_awready,
  input wire logic                   o_s_axi_bvalid,
  input wire logic                   o_s_axi_arready,
  input wire logic                   o_s_axi_rvalid,
  input wire logic [N_CPU-1:0]       o_cpu_req,
  input wire logic [N_CPU*LVL_W-1:0] o_cpu_level,
  input wire logic [N_CPU-1:0]       o_cpu_wake,
  input wire logic [N_CPU*LVL_W-1:0] o_cpu_new_mask,
  input wire logic [N_CPU-1:0]       o_cpu_mask_load
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  // Acceptance by CPU one, and a read address being taken.
  sequence s_accept1;
    o_cpu_req[1] && i_cpu_ack[1];
  endsequence
  sequence s_read_taken;
    o_s_axi_arready;
  endsequence

  a_req_above_mask: assert property (o_cpu_req[0] && $stable(i_cpu_mask_level) |->
    o_cpu_level[3:0] > i_cpu_mask_level[3:0]) else $error("request not above mask");
  a_idle_level_zero: assert property (!o_cpu_req[0] |-> o_cpu_level[3:0] == 4'h0)
    else $error("level shown without request");
  a_accept_drops: assert property (s_accept1 |=> !o_cpu_req[1])
    else $error("request stays after acceptance");
  a_mask_load_value: assert property (o_cpu_mask_load[1] |-> $past(o_cpu_req[1] &&
    i_cpu_ack[1]) && o_cpu_new_mask[7:4] == $past(o_cpu_level[7:4]))
    else $error("bad mask update");
  a_mask_load_pulse: assert property (o_cpu_mask_load[1] |=> !o_cpu_mask_load[1])
    else $error("mask load longer than one cycle");
  a_wake_single: assert property ($onehot0(o_cpu_wake))
    else $error("more than one CPU woken");
  a_wake_asleep: assert property (o_cpu_wake[0] |-> $past(i_cpu_sleep[0]))
    else $error("awake CPU woken");
  a_read_answer: assert property (s_read_taken |=> o_s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (o_s_axi_awready |-> ##[1:3] o_s_axi_bvalid)
    else $error("write answer late");
endmodule : mid_distributor_sva

bind mid_distributor mid_distributor_sva #(.N_CPU(N_CPU), .N_SRC(N_SRC)) i_sva (
  .i_clk, .i_resetn, .i_cpu_ack, .i_cpu_sleep, .i_cpu_mask_level, .o_s_axi_awready,
  .o_s_axi_bvalid, .o_s_axi_arready, .o_s_axi_rvalid, .o_cpu_req, .o_cpu_level,
  .o_cpu_wake, .o_cpu_new_mask, .o_cpu_mask_load);
`default_nettype wire

/* tb/tb_mid_distributor.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_mid_distributor
  import mid_pkg::*;
;
  logic        clk = 1'b0, rstn = 1'b0, nmi = 1'b1, awv = 1'b0, wv = 1'b0;
  logic        bre = 1'b0, arv = 1'b0, rre = 1'b0;
  logic [1:0]  slp = 2'b00, en = 2'b00, rsp;
  logic [7:0]  awa = 8'h00, ara = 8'h00, req = 8'h00, mlv = 8'h00, nr;
  logic [31:0] wd = 32'h0, rd, lf = 32'hf22e;
  logic [4:0]  pri [8];
  wire         awr, wr, bv, arr, rv;
  wire  [1:0]  br, rr, ack, creq, wake, mld;
  wire  [7:0]  lvl, nmask;
  wire  [23:0] evt;
  wire  [31:0] rdat;
  int          bad_count = 0, compares = 0, k, s, b;

  // Free-running clock.
  always #5 clk = ~clk;

  // Device with a fast and a slow CPU model.
  mid_distributor i_dut (.i_clk(clk), .i_resetn(rstn), .i_ce(1'b1), .i_src_req(req),
    .i_nmi_line(nmi), .i_cpu_ack(ack), .i_cpu_sleep(slp), .i_cpu_mask_level(mlv),
    .i_s_axi_awaddr(awa), .i_s_axi_awvalid(awv), .o_s_axi_awready(awr),
    .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hf), .i_s_axi_wvalid(wv), .o_s_axi_wready(wr),
    .o_s_axi_bresp(br), .o_s_axi_bvalid(bv), .i_s_axi_bready(bre),
    .i_s_axi_araddr(ara), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr),
    .o_s_axi_rdata(rdat), .o_s_axi_rresp(rr), .o_s_axi_rvalid(rv), .i_s_axi_rready(rre),
    .o_cpu_req(creq), .o_cpu_level(lvl), .o_cpu_event(evt), .o_cpu_wake(wake),
    .o_cpu_new_mask(nmask), .o_cpu_mask_load(mld));
  mid_cpu_model i_cpu0 (.i_clk(clk), .i_resetn(rstn), .i_req(creq[0]), .i_en(en[0]),
    .i_delay(8'h1e), .o_ack(ack[0]));
  mid_cpu_model i_cpu1 (.i_clk(clk), .i_resetn(rstn), .i_req(creq[1]), .i_en(en[1]),
    .i_delay(8'h00), .o_ack(ack[1]));

  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : nxt

  // Winning source; lower index wins ties, 8 means none.
  function automatic int best(input logic [7:0] r);
    best = 8;
    for (int i = 7; i >= 0; i--) begin
      if (r[i] && pri[i] > 5'h01 && (best == 8 || pri[i] >= pri[best])) best = i;
    end
  endfunction : best

  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk

  task automatic conclude();
    $display("compares=%0d mismatches=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude

  // Bus write: address and data offered together, each released when taken.
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awa <= a;
    wd <= d;
    {awv, wv, bre} <= 3'b111;
    for (int n = 0; n < 60; n++) begin
      @(posedge clk);
      if (awr === 1'b1) awv <= 1'b0;
      if (wr === 1'b1) wv <= 1'b0;
      if (bv === 1'b1) begin
        rsp = br;
        bre <= 1'b0;
        return;
      end
    end
    bad_count++;
    conclude();
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    ara <= a;
    {arv, rre} <= 2'b11;
    for (int n = 0; n < 60; n++) begin
      @(posedge clk);
      if (arr === 1'b1) arv <= 1'b0;
      if (rv === 1'b1) begin
        rd = rdat;
        rsp = rr;
        rre <= 1'b0;
        return;
      end
    end
    bad_count++;
    conclude();
  endtask : rd_reg

  // Lets changes settle, then waits a bounded time for the request level.
  task automatic expect_req(input int c, input logic v);
    repeat (3) @(posedge clk);
    for (int n = 0; n < 10 && creq[c] !== v; n++) @(posedge clk);
    chk({31'h0, v}, {31'h0, creq[c]});
  endtask : expect_req

  // Main sequence of scenarios.
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    wr_reg(8'hfc, 32'hffff_ffff);
    chk({30'h0, RESP_SLVERR}, {30'h0, rsp});
    rd_reg(OFF_PRI_BASE);
    chk(32'h0, rd);
    rd_reg(OFF_MOD_MASK);
    chk(32'hff, rd & 32'hff);
    rd_reg(8'hfc);
    chk({30'h0, RESP_SLVERR}, {30'h0, rsp});
    $display("test reset done");
    wr_reg(OFF_ROUTE_BASE, 32'hff);
    wr_reg(OFF_ROUTE_BASE + 8'h04, 32'hff);
    wr_reg(OFF_MOD_UNMASK, 32'hff);
    for (k = 0; k < 8; k++) begin
      req <= 8'h00;
      for (s = 0; s < 8; s++) begin
        lf = nxt(lf);
        pri[s] = lf[4:0];
        if (k == 0) pri[s] = (s == 2) ? 5'h1a : (s == 5) ? 5'h1b : 5'h01;
        if (k == 1) pri[s] = 5'h14;
        wr_reg(OFF_PRI_BASE + 8'(4 * s), {27'h0, pri[s]});
      end
      lf = nxt(lf);
      nr = (k < 2) ? 8'hf6 : lf[7:0];
      req <= nr;
      b = best(nr);
      expect_req(0, b != 8);
      chk((b == 8) ? 32'h0 : 32'(pri[b] >> 1), 32'(lvl[3:0]));
      if (b != 8) begin
        chk(32'h400 + 32'(b) * 32'h20, 32'(evt[11:0]));
        mlv <= {4'h0, pri[b][4:1]};
        expect_req(0, 1'b0);
        mlv <= {4'h0, pri[b][4:1] - 4'h1};
        expect_req(0, 1'b1);
        mlv <= 8'h00;
      end
      $display("test priority %0d done", k);
    end
    req <= 8'h00;
    wr_reg(OFF_MSG_REQ, 32'h50);
    expect_req(0, 1'b1);
    chk(32'(MSG_EVT_BASE + MSG_EVT_STEP), 32'(evt[11:0]));
    wr_reg(OFF_MSG_CLR, 32'h10);
    rd_reg(OFF_MSG_REQ);
    chk(32'h40, rd);
    wr_reg(OFF_MSG_CLR, 32'h40);
    expect_req(0, 1'b0);
    $display("test message done");
    wr_reg(OFF_CTRL, 32'h1 << CTRL_MAI_BIT);
    wr_reg(OFF_PRI_BASE, 32'h10);
    req <= 8'h01;
    nmi <= 1'b0;
    expect_req(0, 1'b0);
    nmi <= 1'b1;
    expect_req(0, 1'b1);
    $display("test line low done");
    wr_reg(OFF_CTRL, (32'h1 << CTRL_AUTO_BIT) | (32'h1 << CTRL_AMU_BIT));
    en <= 2'b11;
    for (int n = 0; n < 20 && ack[1] !== 1'b1; n++) @(posedge clk);
    chk(32'h1, {31'h0, ack[1]});
    en <= 2'b00;
    expect_req(0, 1'b0);
    rd_reg(OFF_ACK_OWNER);
    chk(32'h0, rd);
    rd_reg(OFF_EVENT_BASE + 8'h04);
    chk(32'h400, rd);
    wr_reg(OFF_PRI_BASE + 8'h04, 32'h0c);
    req <= 8'h03;
    expect_req(0, 1'b1);
    chk(32'h420, 32'(evt[11:0]));
    wr_reg(OFF_ACK_CLR, 32'h1);
    expect_req(0, 1'b1);
    chk(32'h400, 32'(evt[11:0]));
    $display("test automatic done");
    wr_reg(OFF_CTRL, 32'h0);
    slp <= 2'b11;
    expect_req(0, 1'b1);
    chk(32'h1, 32'($countones(wake)));
    mlv <= 8'hff;
    expect_req(0, 1'b0);
    chk(32'h0, {30'h0, wake});
    $display("test wake done");
    conclude();
  end
endmodule : tb_mid_distributor
`default_nettype wire
